//--- dv/motion_tilt_event_engine_test.sv
// self-checking bench of the event engine: defaults, buffer, wake and tilt events
// assumes host model for all inputs but clk and sys_rst, which the bench drives; event ticks shortened to 20 clocks
`timescale 1ns/1ps
module motion_tilt_event_engine_test;
  logic       clk, sys_rst, regWrite, regRead, holdAddress, sampleValid, eventPinOne;
  logic [7:0] regAddr, regWdata, regRdata, sampleX, sampleY, sampleZ;
  int         nMismatch, checkCount;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  mtee_motion_tilt_event_engine #(.TILT_TICKS(20), .WAKE_TICKS(20), .DEPTH(4),
    .WIDE_RANGE(1'b0)) mtee_motion_tilt_event_engine_inst (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
    .holdAddress(holdAddress), .sampleValid(sampleValid), .sampleX(sampleX),
    .sampleY(sampleY), .sampleZ(sampleZ), .eventPinOne(eventPinOne));
  mtee_host_model mtee_host_model_inst (
    .clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .sampleValid(sampleValid),
    .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mtee_host_model_inst.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    mtee_host_model_inst.rd(a, d);
  endtask
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // standby writes first, operate bit last
  task automatic cfg(input logic [15:0] lst [8]);
    foreach (lst[i])
      wr(lst[i][15:8], lst[i][7:0]);
  endtask
  // bounded wait; a hang ends the run as a failure
  task automatic waitPin(input int lim);
    int n;
    n = 0;
    while (eventPinOne !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("pin wait", 8'h01, {7'h00, eventPinOne});
    if (n >= lim)
      finalReport();
  endtask
  task automatic finalReport();
    if (nMismatch == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic resetTest();
    logic [15:0] dflt [12];
    logic [7:0]  d;
    dflt = '{16'h1800, 16'h193F, 16'h1A98, 16'h1C10, 16'h1D00, 16'h1F00,
             16'h2200, 16'h2300, 16'h3000, 16'h320C, 16'h332A, 16'h3414};
    foreach (dflt[i])
    begin
      rd(dflt[i][15:8], d);
      cmp("default", dflt[i][7:0], d);
    end
    wr(mtee_pkg::ADDR_WAKE_THRESH, 8'h5A);
    rd(mtee_pkg::ADDR_WAKE_THRESH, d);
    cmp("threshold", 8'h5A, d);
  endtask
  task automatic bufferTest();
    logic [7:0] d;
    logic [7:0] exp [6];
    exp = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    wr(mtee_pkg::ADDR_MAIN_CTRL, 8'h80);
    mtee_host_model_inst.push(8'h11, 8'h22, 8'h33);
    mtee_host_model_inst.push(8'h44, 8'h55, 8'h66);
    foreach (exp[i])
    begin
      rd(mtee_pkg::ADDR_BUF_READ, d);
      cmp("buffer", exp[i], d);
      cmp("hold", 8'h01, {7'h00, holdAddress});
    end
    wr(mtee_pkg::ADDR_MAIN_CTRL, 8'h00);
  endtask
  // below-threshold motion, then a negative x swing past the limit
  task automatic wakeTest();
    logic [7:0] d;
    mtee_host_model_inst.motion = '{8'h10, 8'h00, 8'h00};
    mtee_host_model_inst.streamOn = 1'b1;
    cfg('{16'h1842, 16'h1A06, 16'h1D7F, 16'h2302, 16'h3008, 16'h1C30, 16'h1F02,
          16'h18C2});
    repeat (200) @(posedge clk);
    cmp("pin quiet", 8'h00, {7'h00, eventPinOne});
    mtee_host_model_inst.motion = '{8'hC0, 8'h00, 8'h00};
    repeat (30) @(posedge clk);
    cmp("pin early", 8'h00, {7'h00, eventPinOne});
    waitPin(100);
    rd(mtee_pkg::ADDR_SOURCE_TWO, d);
    cmp("wake flag", 8'h02, d & 8'h02);
    mtee_host_model_inst.motion = '{8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    rd(mtee_pkg::ADDR_INT_RELEASE, d);
    @(posedge clk);
    #1;
    cmp("pin cleared", 8'h00, {7'h00, eventPinOne});
    repeat (150) @(posedge clk);
    cmp("pin held low", 8'h00, {7'h00, eventPinOne});
    wr(mtee_pkg::ADDR_MAIN_CTRL, 8'h00);
  endtask
  // settle face-up, clear, then turn to x positive
  task automatic tiltTest();
    logic [7:0] d;
    mtee_host_model_inst.motion = '{8'h00, 8'h00, 8'h7F};
    cfg('{16'h1841, 16'h193F, 16'h1A98, 16'h2201, 16'h320C, 16'h1C30, 16'h1F01,
          16'h18C1});
    repeat (150) @(posedge clk);
    rd(mtee_pkg::ADDR_INT_RELEASE, d);
    repeat (3) @(posedge clk);
    mtee_host_model_inst.motion = '{8'h7F, 8'h00, 8'h00};
    waitPin(100);
    rd(mtee_pkg::ADDR_SOURCE_TWO, d);
    cmp("tilt flag", 8'h01, d & 8'h01);
    rd(mtee_pkg::ADDR_STATUS, d);
    cmp("status", 8'h10, d & 8'h10);
    rd(mtee_pkg::ADDR_CUR_ORIENT, d);
    cmp("current", 8'h10, d);
    rd(mtee_pkg::ADDR_PREV_ORIENT, d);
    cmp("previous", 8'h01, d);
    rd(mtee_pkg::ADDR_INT_RELEASE, d);
  endtask
  // reset, then each scenario in turn
  initial
  begin
    sys_rst = 1'b1;
    nMismatch = 0;
    checkCount = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    resetTest();
    bufferTest();
    wakeTest();
    tiltTest();
    finalReport();
  end
endmodule // motion_tilt_event_engine_test

//--- dv/mtee_checker_sva.sv
// checker of the event engine ports: register port, release read, event pin
// assumes it is bound onto the engine top; shadows follow host writes
`timescale 1ns/1ps
module mtee_checker_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       holdAddress,
  input wire logic       eventPinOne
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // shadows of written control values
  // ----------------------------------------
  logic [7:0] pinCtl;
  logic [7:0] route;
  logic [7:0] thresh;
  wire        relRead = regRead && (regAddr == mtee_pkg::ADDR_INT_RELEASE);
  // kept apart from the engine so a stuck register shows up
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinCtl <= mtee_pkg::RST_PIN_CTRL;
      route  <= mtee_pkg::RST_IRQ_ROUTE;
      thresh <= mtee_pkg::RST_WAKE_THRESH;
    end
    else if (regWrite)
    begin
      pinCtl <= (regAddr == mtee_pkg::ADDR_PIN_CTRL) ? regWdata : pinCtl;
      route  <= (regAddr == mtee_pkg::ADDR_IRQ_ROUTE) ? regWdata : route;
      thresh <= (regAddr == mtee_pkg::ADDR_WAKE_THRESH) ? regWdata : thresh;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // release strobe, then the cycle where the latch clears
  sequence sRelease;
    relRead ##1 1'b1;
  endsequence
  chk_hold_buffer: assert property (
    regRead && regAddr == mtee_pkg::ADDR_BUF_READ |-> holdAddress)
    else $error("address hold missing on buffer read");
  chk_release_data: assert property (
    relRead |=> regRdata == 8'h00)
    else $error("release read data not zero");
  chk_release_clear: assert property (
    sRelease |=> !eventPinOne)
    else $error("pin still high after release read");
  chk_thresh_readback: assert property (
    regRead && regAddr == mtee_pkg::ADDR_WAKE_THRESH |=> regRdata == $past(thresh))
    else $error("threshold read back differs");
  chk_pin_reset: assert property (
    $fell(sys_rst) |-> !eventPinOne)
    else $error("pin high after reset");
  chk_pin_enabled: assert property (
    $rose(eventPinOne) |-> pinCtl[mtee_pkg::PIN_ENABLE_BIT])
    else $error("pin rose while disabled");
  chk_pin_latched: assert property (
    eventPinOne && !relRead && !$past(relRead) && !regWrite && !$past(regWrite)
    |=> eventPinOne)
    else $error("latched pin dropped without release");
  chk_pin_routed: assert property (
    $rose(eventPinOne) |-> route[1:0] != 2'b00)
    else $error("pin rose with no event routed");
endmodule // mtee_checker_sva
bind mtee_motion_tilt_event_engine mtee_checker_sva mtee_checker_sva_inst (
  .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
  .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
  .holdAddress(holdAddress), .eventPinOne(eventPinOne)
);

//--- dv/mtee_host_model.sv
// host model of the event engine: register accesses and the sample source
// assumes one clock; every request launched and released on rising edges
`timescale 1ns/1ps
module mtee_host_model (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  output logic            regRead,
  input  wire logic [7:0] regRdata,
  output logic            sampleValid,
  output logic      [7:0] sampleX,
  output logic      [7:0] sampleY,
  output logic      [7:0] sampleZ
);
  logic       streamOn;
  logic [7:0] motion [3];
  // quiet port at time zero
  initial
  begin
    {regAddr, regWrite, regWdata, regRead} = '0;
    {sampleValid, sampleX, sampleY, sampleZ} = '0;
    streamOn = 1'b0;
    motion = '{8'h00, 8'h00, 8'h00};
  end
  // free-running samples every other cycle, only while streaming
  always @(posedge clk)
  begin
    if (streamOn)
    begin
      sampleValid <= !sampleValid;
      {sampleX, sampleY, sampleZ} <= {motion[0], motion[1], motion[2]};
    end
  end
  // one write strobe; a second call leaves a gap cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // address kept with the read phase, no stop in between
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // single sample, used only while the stream is off
  task automatic push(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge clk);
    {sampleValid, sampleX, sampleY, sampleZ} <= {1'b1, x, y, z};
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask
endmodule // mtee_host_model

//--- hdl/mtee_motion_tilt_event_engine.sv
// motion/tilt event engine: registers, wake-up and tilt detectors, pin, buffer port
// assumes a serial front end presents register accesses as single-cycle strobes,
// and the sample path presents signed 8-bit x/y/z samples with a valid strobe
`timescale 1ns/1ps
module mtee_motion_tilt_event_engine #(
  parameter int TILT_TICKS = mtee_pkg::TILT_PERIOD,
  parameter int WAKE_TICKS = mtee_pkg::WAKE_PERIOD,
  parameter int DEPTH      = mtee_pkg::BUF_DEPTH,
  parameter bit WIDE_RANGE = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic            holdAddress,
  input  wire logic       sampleValid,
  input  wire logic [7:0] sampleX,
  input  wire logic [7:0] sampleY,
  input  wire logic [7:0] sampleZ,
  output logic            eventPinOne
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] mainControl, tiltDirectionMask, engineRateControl, irqPinControl;
  logic [7:0] wakeDirectionMask, irqRouting, tiltDebounceTimer, wakePersistenceCount;
  logic [7:0] wakeThreshold, tiltLowAngle, tiltHighAngle, orientationHysteresis;
  logic [5:0] currentOrientation, previousOrientation;
  logic       wakeFlag, tiltFlag, pinLatch;
  logic       wakeEvent, tiltEvent;

  function automatic logic hit(input logic [7:0] a);
    return regAddr == a;
  endfunction

  // software writes; registers may change in any mode, safe only in standby
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mainControl           <= mtee_pkg::RST_MAIN_CTRL;
      tiltDirectionMask     <= mtee_pkg::RST_TILT_MASK;
      engineRateControl     <= mtee_pkg::RST_RATE_CTRL;
      irqPinControl         <= mtee_pkg::RST_PIN_CTRL;
      wakeDirectionMask     <= mtee_pkg::RST_WAKE_MASK;
      irqRouting            <= mtee_pkg::RST_IRQ_ROUTE;
      tiltDebounceTimer     <= mtee_pkg::RST_TILT_TIMER;
      wakePersistenceCount  <= mtee_pkg::RST_WAKE_PERSIST;
      wakeThreshold         <= mtee_pkg::RST_WAKE_THRESH;
      tiltLowAngle          <= mtee_pkg::RST_TILT_LOW;
      tiltHighAngle         <= mtee_pkg::RST_TILT_HIGH;
      orientationHysteresis <= mtee_pkg::RST_HYST;
    end
    else if (regWrite)
    begin
      if (hit(mtee_pkg::ADDR_MAIN_CTRL))    mainControl           <= regWdata;
      if (hit(mtee_pkg::ADDR_TILT_MASK))    tiltDirectionMask     <= regWdata;
      if (hit(mtee_pkg::ADDR_RATE_CTRL))    engineRateControl     <= regWdata;
      if (hit(mtee_pkg::ADDR_PIN_CTRL))     irqPinControl         <= regWdata;
      if (hit(mtee_pkg::ADDR_WAKE_MASK))    wakeDirectionMask     <= regWdata;
      if (hit(mtee_pkg::ADDR_IRQ_ROUTE))    irqRouting            <= regWdata;
      if (hit(mtee_pkg::ADDR_TILT_TIMER))   tiltDebounceTimer     <= regWdata;
      if (hit(mtee_pkg::ADDR_WAKE_PERSIST)) wakePersistenceCount  <= regWdata;
      if (hit(mtee_pkg::ADDR_WAKE_THRESH))  wakeThreshold         <= regWdata;
      if (hit(mtee_pkg::ADDR_TILT_LOW))     tiltLowAngle          <= regWdata;
      if (hit(mtee_pkg::ADDR_TILT_HIGH))    tiltHighAngle         <= regWdata;
      if (hit(mtee_pkg::ADDR_HYST))         orientationHysteresis <= regWdata;
    end
  end

  // mode decode
  logic operating, wakeEnabled, tiltEnabled;
  assign operating   = mainControl[mtee_pkg::MAIN_OPERATE_BIT];
  assign wakeEnabled = operating && mainControl[mtee_pkg::MAIN_WAKE_EN_BIT];
  assign tiltEnabled = operating && mainControl[mtee_pkg::MAIN_TILT_EN_BIT];

  // ---------------------------------------------------------------
  // sample buffer
  // ---------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  logic [7:0]    bufMem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr;
  logic [AW:0]   fill;
  logic [1:0]    rdLane;
  logic          bufPop;
  logic          bufAdvance;
  assign bufPop      = regRead && hit(mtee_pkg::ADDR_BUF_READ) && fill != '0;
  // a slot is freed only after its z byte, so x,y,z come from one sample
  assign bufAdvance  = bufPop && rdLane == 2'd2;
  assign holdAddress = hit(mtee_pkg::ADDR_BUF_READ);

  // one sample per slot, bytes x,y,z; full buffer drops new samples
  always_ff @(posedge clk)
  begin
    if (sampleValid && operating && fill != (AW+1)'(DEPTH))
      bufMem[wrPtr] <= sampleX;
    if (sys_rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end
    else
    begin
      if (sampleValid && operating && fill != (AW+1)'(DEPTH))
        wrPtr <= wrPtr + 1'b1;
      if (bufAdvance)
        rdPtr <= rdPtr + 1'b1;
      fill <= fill + (AW+1)'(sampleValid && operating && fill != (AW+1)'(DEPTH))
                   - (AW+1)'(bufAdvance);
    end
  end

  // y and z follow the stored x in a small side store
  logic [7:0] bufY [DEPTH];
  logic [7:0] bufZ [DEPTH];
  always_ff @(posedge clk)
  begin
    if (sampleValid && operating && fill != (AW+1)'(DEPTH))
    begin
      bufY[wrPtr] <= sampleY;
      bufZ[wrPtr] <= sampleZ;
    end
  end

  // lane walks x, y, z on successive reads of the same address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdLane <= 2'd0;
    else if (regRead && hit(mtee_pkg::ADDR_BUF_READ) && fill != '0)
      rdLane <= (rdLane == 2'd2) ? 2'd0 : rdLane + 2'd1;
  end

  // ---------------------------------------------------------------
  // rate ticks
  // ---------------------------------------------------------------
  logic [31:0] wakeCnt, tiltCnt;
  logic        wakeTick, tiltTick;
  assign wakeTick = wakeCnt == 32'(WAKE_TICKS - 1);
  assign tiltTick = tiltCnt == 32'(TILT_TICKS - 1);
  // only the documented rate codes run; other codes leave the engine idle
  always_ff @(posedge clk)
  begin
    if (sys_rst || !wakeEnabled ||
        engineRateControl[2:0] != mtee_pkg::WAKE_RATE_50HZ)
      wakeCnt <= '0;
    else
      wakeCnt <= wakeTick ? '0 : wakeCnt + 32'd1;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || !tiltEnabled ||
        engineRateControl[7:6] != mtee_pkg::TILT_RATE_12HZ)
      tiltCnt <= '0;
    else
      tiltCnt <= tiltTick ? '0 : tiltCnt + 32'd1;
  end

  // latest sample held for both engines
  logic signed [7:0] ax, ay, az;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ax <= '0;
      ay <= '0;
      az <= '0;
    end
    else if (sampleValid)
    begin
      ax <= sampleX;
      ay <= sampleY;
      az <= sampleZ;
    end
  end

  // ---------------------------------------------------------------
  // wake-up engine
  // ---------------------------------------------------------------
  // threshold in units of 4 sample counts (1 in wide range): 1 g = 64 lsb of the 8-bit sample (assumed)
  function automatic logic over(input logic signed [7:0] v, input logic neg);
    logic [9:0] lim;
    lim = WIDE_RANGE ? {wakeThreshold, 2'b00} >> 2 : {2'b00, wakeThreshold} << 2;
    return neg ? (v < 0 && 10'(-v) > lim) : (v > 0 && 10'(v) > lim);
  endfunction
  logic [5:0] dirHit;
  assign dirHit = {over(ax, 1'b1), over(ax, 1'b0), over(ay, 1'b1),
                   over(ay, 1'b0), over(az, 1'b1), over(az, 1'b0)};
  logic       motion;
  assign motion = |(dirHit & wakeDirectionMask[5:0]);
  logic [7:0] persistCnt;
  always_ff @(posedge clk)
  begin
    wakeEvent <= 1'b0;
    if (sys_rst || !wakeEnabled)
      persistCnt <= '0;
    else if (wakeTick)
    begin
      if (!motion)
        persistCnt <= '0;
      else if (persistCnt >= wakePersistenceCount)
        wakeEvent <= 1'b1;
      else
        persistCnt <= persistCnt + 8'd1;
    end
  end

  // ---------------------------------------------------------------
  // tilt engine
  // ---------------------------------------------------------------
  // orientation one-hot: x-,x+,y-,y+,z-,z+ ; axis above high, for x or y the other of x,y below low plus hysteresis[7:2]
  logic [5:0] rawOrient, candOrient;
  logic [7:0] tiltStable;
  function automatic logic [7:0] mag(input logic signed [7:0] v);
    return (v < 0) ? 8'(-v) >> 1 : 8'(v) >> 1;
  endfunction
  always_comb
  begin
    rawOrient = '0;
    if (mag(ax) > tiltHighAngle && mag(ay) < tiltLowAngle + orientationHysteresis[7:2])
      rawOrient = ax < 0 ? 6'b100000 : 6'b010000;
    else if (mag(ay) > tiltHighAngle && mag(ax) < tiltLowAngle + orientationHysteresis[7:2])
      rawOrient = ay < 0 ? 6'b001000 : 6'b000100;
    else if (mag(az) > tiltHighAngle)
      rawOrient = az < 0 ? 6'b000010 : 6'b000001;
    rawOrient = rawOrient & tiltDirectionMask[5:0];
  end
  always_ff @(posedge clk)
  begin
    tiltEvent <= 1'b0;
    if (sys_rst)
    begin
      candOrient          <= '0;
      tiltStable          <= '0;
      currentOrientation  <= '0;
      previousOrientation <= '0;
    end
    else if (tiltEnabled && tiltTick)
    begin
      if (rawOrient != candOrient || rawOrient == '0)
      begin
        candOrient <= rawOrient;
        tiltStable <= '0;
      end
      else if (rawOrient != currentOrientation)
      begin
        if (tiltStable + 8'd1 >= tiltDebounceTimer)
        begin
          previousOrientation <= currentOrientation;
          currentOrientation  <= rawOrient;
          tiltEvent           <= 1'b1;
        end
        else
          tiltStable <= tiltStable + 8'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt latch and pin
  // ---------------------------------------------------------------
  logic releaseRead;
  assign releaseRead = regRead && hit(mtee_pkg::ADDR_INT_RELEASE);
  logic routed;
  assign routed = (wakeEvent && irqRouting[mtee_pkg::ROUTE_WAKE_BIT]) ||
                  (tiltEvent && irqRouting[mtee_pkg::ROUTE_TILT_BIT]);
  // a new event in the release cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wakeFlag <= 1'b0;
      tiltFlag <= 1'b0;
      pinLatch <= 1'b0;
    end
    else
    begin
      wakeFlag <= wakeEvent || (wakeFlag && !releaseRead);
      tiltFlag <= tiltEvent || (tiltFlag && !releaseRead);
      pinLatch <= routed    || (pinLatch && !releaseRead);
    end
  end
  logic pinOn;
  assign pinOn = irqPinControl[mtee_pkg::PIN_ENABLE_BIT] &&
                 (irqPinControl[mtee_pkg::PIN_PULSE_BIT] ? routed : pinLatch);
  // registered output; polarity bit low turns the pin active low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      eventPinOne <= 1'b0;
    else
      eventPinOne <= irqPinControl[mtee_pkg::PIN_POLARITY_BIT] ? pinOn : !pinOn;
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRdata <= '0;
    else if (regRead)
    begin
      unique case (regAddr)
        mtee_pkg::ADDR_MAIN_CTRL:    regRdata <= mainControl;
        mtee_pkg::ADDR_TILT_MASK:    regRdata <= tiltDirectionMask;
        mtee_pkg::ADDR_RATE_CTRL:    regRdata <= engineRateControl;
        mtee_pkg::ADDR_PIN_CTRL:     regRdata <= irqPinControl;
        mtee_pkg::ADDR_WAKE_MASK:    regRdata <= wakeDirectionMask;
        mtee_pkg::ADDR_IRQ_ROUTE:    regRdata <= irqRouting;
        mtee_pkg::ADDR_TILT_TIMER:   regRdata <= tiltDebounceTimer;
        mtee_pkg::ADDR_WAKE_PERSIST: regRdata <= wakePersistenceCount;
        mtee_pkg::ADDR_WAKE_THRESH:  regRdata <= wakeThreshold;
        mtee_pkg::ADDR_TILT_LOW:     regRdata <= tiltLowAngle;
        mtee_pkg::ADDR_TILT_HIGH:    regRdata <= tiltHighAngle;
        mtee_pkg::ADDR_HYST:         regRdata <= orientationHysteresis;
        mtee_pkg::ADDR_CUR_ORIENT:   regRdata <= {2'b00, currentOrientation};
        mtee_pkg::ADDR_PREV_ORIENT:  regRdata <= {2'b00, previousOrientation};
        mtee_pkg::ADDR_STATUS:       regRdata <= {3'b000, wakeFlag || tiltFlag, 4'h0};
        mtee_pkg::ADDR_SOURCE_TWO:   regRdata <= {6'b0, wakeFlag, tiltFlag};
        mtee_pkg::ADDR_BUF_READ:
          regRdata <= (fill == '0) ? 8'h00 :
                      (rdLane == 2'd0) ? bufMem[rdPtr] :
                      (rdLane == 2'd1) ? bufY[rdPtr] : bufZ[rdPtr];
        default:                     regRdata <= 8'h00;  // release and unmapped
      endcase
    end
  end
endmodule // mtee_motion_tilt_event_engine

//--- inc/mtee_pkg.sv
// package of the motion/tilt event engine: register map, fields, resets, timing
// assumes a register port (address, write strobe, read strobe) from a serial front end
package mtee_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INT_RELEASE  = 8'h17;
  localparam logic [7:0] ADDR_MAIN_CTRL    = 8'h18;
  localparam logic [7:0] ADDR_TILT_MASK    = 8'h19;
  localparam logic [7:0] ADDR_RATE_CTRL    = 8'h1A;
  localparam logic [7:0] ADDR_PIN_CTRL     = 8'h1C;
  localparam logic [7:0] ADDR_WAKE_MASK    = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_ROUTE    = 8'h1F;
  localparam logic [7:0] ADDR_TILT_TIMER   = 8'h22;
  localparam logic [7:0] ADDR_WAKE_PERSIST = 8'h23;
  localparam logic [7:0] ADDR_WAKE_THRESH  = 8'h30;
  localparam logic [7:0] ADDR_TILT_LOW     = 8'h32;
  localparam logic [7:0] ADDR_TILT_HIGH    = 8'h33;
  localparam logic [7:0] ADDR_HYST         = 8'h34;
  localparam logic [7:0] ADDR_BUF_READ     = 8'h3F;
  localparam logic [7:0] ADDR_STATUS       = 8'h15;
  localparam logic [7:0] ADDR_SOURCE_TWO   = 8'h13;
  localparam logic [7:0] ADDR_CUR_ORIENT   = 8'h10;
  localparam logic [7:0] ADDR_PREV_ORIENT  = 8'h11;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MAIN_OPERATE_BIT  = 7;
  localparam int MAIN_HIGHRES_BIT  = 6;
  localparam int MAIN_WAKE_EN_BIT  = 1;
  localparam int MAIN_TILT_EN_BIT  = 0;
  localparam int PIN_ENABLE_BIT    = 5;
  localparam int PIN_POLARITY_BIT  = 4;
  localparam int PIN_PULSE_BIT     = 3;
  localparam int ROUTE_WAKE_BIT    = 1;
  localparam int ROUTE_TILT_BIT    = 0;
  localparam int STATUS_INT_BIT    = 4;
  localparam int SOURCE_WAKE_BIT   = 1;
  localparam int SOURCE_TILT_BIT   = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MAIN_CTRL   = 8'h00;
  localparam logic [7:0] RST_TILT_MASK   = 8'h3F;
  localparam logic [7:0] RST_RATE_CTRL   = 8'h98;
  localparam logic [7:0] RST_PIN_CTRL    = 8'h10;
  localparam logic [7:0] RST_WAKE_MASK   = 8'h00;
  localparam logic [7:0] RST_IRQ_ROUTE   = 8'h00;
  localparam logic [7:0] RST_TILT_TIMER  = 8'h00;
  localparam logic [7:0] RST_WAKE_PERSIST= 8'h00;
  localparam logic [7:0] RST_WAKE_THRESH = 8'h00;
  localparam logic [7:0] RST_TILT_LOW    = 8'h0C;
  localparam logic [7:0] RST_TILT_HIGH   = 8'h2A;
  localparam logic [7:0] RST_HYST        = 8'h14;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int TILT_RATE_MHZ= 12_500;          // 12.5 Hz in millihertz
  localparam int WAKE_RATE_HZ = 50;              // wake rate at code 0x06
  localparam int TILT_PERIOD  = (CLK_HZ / TILT_RATE_MHZ) * 1000;
  localparam int WAKE_PERIOD  = CLK_HZ / WAKE_RATE_HZ;
  localparam logic [2:0] WAKE_RATE_50HZ = 3'h6;  // low bits of rate control
  localparam logic [1:0] TILT_RATE_12HZ = 2'h2;  // top bits of rate control, 0x98 -> 2
  localparam int BUF_DEPTH    = 64;
endpackage
